// File: hdl/pps_mux.v
// Pin share multiplexer for port 1 and port 2.
// Assumes peripheral control bits and pad inputs are synchronous to clk_i;
// the reset option strap is stable from power-up.
`include "pps_consts.vh"

module pps_mux (
    input wire clk_i,
    input wire reset_i,
    // ==========================================================
    // Port 1 registers and pads
    input wire [7:0] p1_data_i,
    input wire [7:0] p1_dir_i,
    input wire [7:0] p1_pullup_i,
    input wire [7:0] p1_pad_in_i,
    output wire [7:0] p1_pad_out_o,
    output wire [7:0] p1_pad_oe_o,
    output wire [7:0] p1_pad_pu_o,
    output reg [7:0] p1_pin_read_o,
    output reg [7:0] p1_shared_o,
    // ==========================================================
    // Port 2 registers and pads
    input wire [7:0] p2_data_i,
    input wire [7:0] p2_dir_i,
    input wire [7:0] p2_pullup_i,
    input wire [7:0] p2_pad_in_i,
    output wire [7:0] p2_pad_out_o,
    output wire [7:0] p2_pad_oe_o,
    output wire [7:0] p2_pad_pu_o,
    output reg [7:0] p2_pin_read_o,
    output reg [7:0] p2_shared_o,
    // ==========================================================
    // Group-4 interrupts
    input wire ext_int_group4_enable_i,
    input wire [7:0] int_group4_source_select_i,
    output reg [7:0] group4_irq_o,
    // ==========================================================
    // Converter
    input wire [3:0] adc_pin_channel_connect_i,
    input wire converter_power_on_i,
    input wire [2:0] converter_channel_select_i,
    output reg [3:0] analog_input_connect_o,
    // ==========================================================
    // Timer 0
    input wire timer0_run_i,
    input wire timer0_counter_mode_i,
    output reg timer0_ext_input_o,
    // ==========================================================
    // Reset pin option
    input wire reset_pin_option_i,
    output reg reset_pin_selected_o,
    output reg reset_pin_level_o,
    // ==========================================================
    // PWM
    input wire pwm_out11_enable_i,
    input wire pwm_out01_enable_i,
    input wire pwm_ch1_enable_i,
    input wire pwm_ch0_enable_i,
    input wire pwm_ch2_enable_i,
    input wire pwm_out11_i,
    input wire pwm_out01_i,
    input wire pwm_ch1_i,
    input wire pwm_ch0_i,
    input wire pwm_ch2_i,
    // ==========================================================
    // UART
    input wire uart_rx_enable_i,
    input wire uart_tx_buffer_write_i,
    input wire uart_tx_release_i,
    input wire uart_txd_i,
    output reg uart_rxd_o,
    output reg uart_tx_owned_o,
    // ==========================================================
    // SPI
    input wire spi_enable_i,
    input wire spi_master_i,
    input wire spi_clock_phase_i,
    input wire slave_select_disable_i,
    input wire spi_miso_out_i,
    input wire spi_sck_out_i,
    output reg spi_mosi_in_o,
    output reg spi_miso_in_o,
    output reg spi_sck_in_o,
    // ==========================================================
    // Buzzer
    input wire buzzer_enable_i,
    input wire buzzer_output_i
);

    // ==========================================================
    // Reset option capture
    reg opt_loaded;
    reg reset_option;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            opt_loaded <= 1'b0;
            reset_option <= `PPS_OPT_RESET;
        end else if (!opt_loaded) begin
            opt_loaded <= 1'b1;
            reset_option <= reset_pin_option_i;
        end
    end

    // ==========================================================
    // UART transmit pin claim
    reg tx_owned;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_owned <= 1'b0;
        end else if (uart_tx_buffer_write_i) begin
            tx_owned <= 1'b1;
        end else if (uart_tx_release_i) begin
            tx_owned <= 1'b0;
        end
    end

    // ==========================================================
    // Group-4 interrupt requests
    wire [7:0] g4_req;
    wire [7:0] g4_dir;

    assign g4_dir[`PPS_G4_P1_0] = p1_dir_i[0];
    assign g4_dir[`PPS_G4_P1_1] = p1_dir_i[1];
    assign g4_dir[`PPS_G4_P1_2] = p1_dir_i[2];
    assign g4_dir[`PPS_G4_P1_3] = p1_dir_i[3];
    assign g4_dir[`PPS_G4_P1_4] = p1_dir_i[4];
    assign g4_dir[`PPS_G4_P1_5] = p1_dir_i[5];
    assign g4_dir[`PPS_G4_P2_6] = p2_dir_i[6];
    assign g4_dir[`PPS_G4_P2_7] = p2_dir_i[7];

    assign g4_req = {8{ext_int_group4_enable_i}} & int_group4_source_select_i & ~g4_dir;

    // ==========================================================
    // Analog channel requests
    wire [3:0] an_req;
    wire [2:0] an_code [0:3];

    assign an_code[0] = `PPS_CHSEL_AN4;
    assign an_code[1] = `PPS_CHSEL_AN5;
    assign an_code[2] = `PPS_CHSEL_AN6;
    assign an_code[3] = `PPS_CHSEL_AN7;

    genvar ai;
    generate
        for (ai = 0; ai < 4; ai = ai + 1) begin : g_an
            assign an_req[ai] = adc_pin_channel_connect_i[ai] & converter_power_on_i &
                                (converter_channel_select_i == an_code[ai]);
        end
    endgenerate

    // ==========================================================
    // Other function requests
    wire t0_req = timer0_run_i & timer0_counter_mode_i;
    wire spi_slave = spi_enable_i & ~spi_master_i;
    wire spi_slave_pu = spi_slave & spi_clock_phase_i & slave_select_disable_i;

    // ==========================================================
    // Port 1 priority resolution
    reg [7:0] p1_own;
    reg [7:0] p1_foe;
    reg [7:0] p1_fout;
    reg [7:0] p1_fpu;
    reg [3:0] an_own;
    integer k;

    always @* begin
        p1_own = 8'h00;
        p1_foe = 8'h00;
        p1_fout = 8'h00;
        p1_fpu = 8'h00;
        an_own = 4'h0;
        if (g4_req[`PPS_G4_P1_0]) begin
            p1_own[0] = 1'b1;
        end
        if (g4_req[`PPS_G4_P1_1]) begin
            p1_own[1] = 1'b1;
        end
        for (k = 0; k < 4; k = k + 1) begin
            if (g4_req[`PPS_G4_P1_2 - k]) begin
                p1_own[k + 2] = 1'b1;
            end else if (an_req[k]) begin
                p1_own[k + 2] = 1'b1;
                an_own[k] = 1'b1;
            end
        end
        if (t0_req) begin
            p1_own[6] = 1'b1;
            p1_fpu[6] = 1'b1;
        end
        if (reset_option) begin
            p1_own[7] = 1'b1;
        end
    end

    // ==========================================================
    // Port 2 priority resolution
    reg [7:0] p2_own;
    reg [7:0] p2_foe;
    reg [7:0] p2_fout;
    reg [7:0] p2_fpu;

    always @* begin
        p2_own = 8'h00;
        p2_foe = 8'h00;
        p2_fout = 8'h00;
        p2_fpu = 8'h00;
        if (pwm_out11_enable_i) begin
            p2_own[7] = 1'b1;
            p2_foe[7] = 1'b1;
            p2_fout[7] = pwm_out11_i;
        end else if (g4_req[`PPS_G4_P2_7]) begin
            p2_own[7] = 1'b1;
        end
        if (pwm_out01_enable_i) begin
            p2_own[6] = 1'b1;
            p2_foe[6] = 1'b1;
            p2_fout[6] = pwm_out01_i;
        end else if (g4_req[`PPS_G4_P2_6]) begin
            p2_own[6] = 1'b1;
        end
        if (pwm_ch1_enable_i) begin
            p2_own[5] = 1'b1;
            p2_foe[5] = 1'b1;
            p2_fout[5] = pwm_ch1_i;
        end
        if (pwm_ch0_enable_i) begin
            p2_own[4] = 1'b1;
            p2_foe[4] = 1'b1;
            p2_fout[4] = pwm_ch0_i;
        end
        if (pwm_ch2_enable_i) begin
            p2_own[3] = 1'b1;
            p2_foe[3] = 1'b1;
            p2_fout[3] = pwm_ch2_i;
        end
        if (uart_rx_enable_i) begin
            p2_own[2] = 1'b1;
            p2_fpu[2] = 1'b1;
        end else if (spi_slave) begin
            p2_own[2] = 1'b1;
            p2_fpu[2] = spi_slave_pu;
        end
        if (tx_owned) begin
            p2_own[1] = 1'b1;
            p2_foe[1] = 1'b1;
            p2_fout[1] = uart_txd_i;
        end else if (spi_enable_i) begin
            p2_own[1] = 1'b1;
            p2_foe[1] = ~spi_master_i;
            p2_fout[1] = spi_miso_out_i;
            p2_fpu[1] = spi_master_i;
        end
        if (buzzer_enable_i) begin
            p2_own[0] = 1'b1;
            p2_foe[0] = 1'b1;
            p2_fout[0] = buzzer_output_i;
        end else if (spi_enable_i) begin
            p2_own[0] = 1'b1;
            p2_foe[0] = spi_master_i;
            p2_fout[0] = spi_sck_out_i;
            p2_fpu[0] = spi_slave_pu;
        end
    end

    // ==========================================================
    // Pad output stages
    wire [15:0] all_own = {p2_own, p1_own};
    wire [15:0] all_foe = {p2_foe, p1_foe};
    wire [15:0] all_fout = {p2_fout, p1_fout};
    wire [15:0] all_fpu = {p2_fpu, p1_fpu};
    wire [15:0] all_data = {p2_data_i, p1_data_i};
    wire [15:0] all_dir = {p2_dir_i, p1_dir_i};
    wire [15:0] all_pu = {p2_pullup_i, p1_pullup_i};
    wire [15:0] all_out;
    wire [15:0] all_oe;
    wire [15:0] all_ppu;

    genvar pi;
    generate
        for (pi = 0; pi < 16; pi = pi + 1) begin : g_pad
            pps_pad_cell u_cell (
                .clk_i(clk_i),
                .reset_i(reset_i),
                .own_i(all_own[pi]),
                .func_oe_i(all_foe[pi]),
                .func_out_i(all_fout[pi]),
                .func_pu_i(all_fpu[pi]),
                .gpio_data_i(all_data[pi]),
                .gpio_dir_i(all_dir[pi]),
                .gpio_pu_i(all_pu[pi]),
                .pad_out_o(all_out[pi]),
                .pad_oe_o(all_oe[pi]),
                .pad_pu_o(all_ppu[pi])
            );
        end
    endgenerate

    assign p1_pad_out_o = all_out[7:0];
    assign p1_pad_oe_o = all_oe[7:0];
    assign p1_pad_pu_o = all_ppu[7:0];
    assign p2_pad_out_o = all_out[15:8];
    assign p2_pad_oe_o = all_oe[15:8];
    assign p2_pad_pu_o = all_ppu[15:8];

    // ==========================================================
    // Peripheral input routing
    reg [7:0] next_irq;
    integer j;

    always @* begin
        next_irq = {8{`PPS_IN_IDLE}};
        if (p1_own[0]) next_irq[`PPS_G4_P1_0] = p1_pad_in_i[0];
        if (p1_own[1]) next_irq[`PPS_G4_P1_1] = p1_pad_in_i[1];
        for (j = 0; j < 4; j = j + 1) begin
            if (p1_own[j + 2] && !an_own[j]) begin
                next_irq[`PPS_G4_P1_2 - j] = p1_pad_in_i[j + 2];
            end
        end
        if (p2_own[6] && !pwm_out01_enable_i) next_irq[`PPS_G4_P2_6] = p2_pad_in_i[6];
        if (p2_own[7] && !pwm_out11_enable_i) next_irq[`PPS_G4_P2_7] = p2_pad_in_i[7];
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            group4_irq_o <= {8{`PPS_IN_IDLE}};
            analog_input_connect_o <= 4'h0;
            timer0_ext_input_o <= `PPS_IN_IDLE;
            reset_pin_selected_o <= `PPS_OPT_RESET;
            reset_pin_level_o <= `PPS_IN_IDLE;
            uart_rxd_o <= `PPS_IN_IDLE;
            uart_tx_owned_o <= 1'b0;
            spi_mosi_in_o <= `PPS_IN_IDLE;
            spi_miso_in_o <= `PPS_IN_IDLE;
            spi_sck_in_o <= `PPS_IN_IDLE;
            p1_pin_read_o <= 8'h00;
            p2_pin_read_o <= 8'h00;
            p1_shared_o <= 8'h00;
            p2_shared_o <= 8'h00;
        end else begin
            group4_irq_o <= next_irq;
            analog_input_connect_o <= an_own;
            timer0_ext_input_o <= t0_req ? p1_pad_in_i[6] : `PPS_IN_IDLE;
            reset_pin_selected_o <= reset_option;
            reset_pin_level_o <= reset_option ? p1_pad_in_i[7] : `PPS_IN_IDLE;
            uart_rxd_o <= uart_rx_enable_i ? p2_pad_in_i[2] : `PPS_IN_IDLE;
            uart_tx_owned_o <= tx_owned;
            spi_mosi_in_o <= (!uart_rx_enable_i && spi_slave) ? p2_pad_in_i[2] : `PPS_IN_IDLE;
            spi_miso_in_o <= (!tx_owned && spi_enable_i && spi_master_i) ? p2_pad_in_i[1] : `PPS_IN_IDLE;
            spi_sck_in_o <= (!buzzer_enable_i && spi_slave) ? p2_pad_in_i[0] : `PPS_IN_IDLE;
            p1_pin_read_o <= p1_pad_in_i;
            p2_pin_read_o <= p2_pad_in_i;
            p1_shared_o <= p1_own;
            p2_shared_o <= p2_own;
        end
    end

endmodule

// File: hdl/pps_consts.vh
// Constants for the port 1 / port 2 pin share multiplexer.
// Assumes inclusion by bare name from the design files under hdl/.
//
// Summary of operation
// - Group-4 interrupt on P1.0-P1.5 needs group enable, source bit, input direction.
// - On P1.2-P1.5 group-4 interrupt beats analog input, which beats GPIO.
// - Analog inputs 4-7 need channel bit, converter on, channel select 100-111.
// - Clearing an analog channel bit on P1.2-P1.5 returns the pin to GPIO.
// - Timer-0 input owns P1.6 when run and counter mode set, with pull-up.
// - P1.7 is reset input or GPIO, chosen by a fixed option strap.
// - P2.7 carries PWM out 11 when enabled, else group-4 irq 46, else GPIO.
// - P2.6 carries PWM out 01 when enabled, else group-4 irq 45, else GPIO.
// - P2.5, P2.4, P2.3 output PWM 1, 0, 2 while enabled, else GPIO.
// - P2.2 is UART receive with pull-up once receive enabled, above SPI.
// - Second priority, P2.2 is SPI MOSI input when SPI enabled as slave.
// - Slave with SPI enable, clock phase, select disable pulls up MOSI and SCK.
// - P2.1 becomes UART transmit once the transmit buffer is written, above SPI.
// - Second priority, P2.1 is SPI MISO when SPI enabled; master adds pull-up.
// - P2.0 drives buzzer output when buzzer enabled, above SPI clock.
// - Second priority, P2.0 is SPI serial clock when SPI enabled.
// - A shared pin with no enabled function behaves as plain GPIO.
// - Highest-priority enabled function owns the pin; lower ones wait.
// - Port data, pull-up changes do not reach an owned pin; setting direction to output releases a group-4 pin.
`ifndef PPS_CONSTS_VH
`define PPS_CONSTS_VH

// ====
// Converter channel select codes for analog inputs 4 to 7
`define PPS_CHSEL_AN4 3'h4
`define PPS_CHSEL_AN5 3'h5
`define PPS_CHSEL_AN6 3'h6
`define PPS_CHSEL_AN7 3'h7

// ====
// Group-4 source select bit index per pin
`define PPS_G4_P1_0 7
`define PPS_G4_P1_1 4
`define PPS_G4_P1_2 3
`define PPS_G4_P1_3 2
`define PPS_G4_P1_4 1
`define PPS_G4_P1_5 0
`define PPS_G4_P2_6 5
`define PPS_G4_P2_7 6

// ====
// Reset and idle values
`define PPS_PAD_RESET_OUT 1'b0
`define PPS_PAD_RESET_OE 1'b0
`define PPS_PAD_RESET_PU 1'b0
`define PPS_IN_IDLE 1'b1
`define PPS_OPT_RESET 1'b0

`endif

// File: hdl/pps_pad_cell.v
// One pad's output stage: owning function or GPIO drives the pad.
// Assumes the function request is already priority-resolved.
`include "pps_consts.vh"

module pps_pad_cell (
    input wire clk_i,
    input wire reset_i,
    input wire own_i,
    input wire func_oe_i,
    input wire func_out_i,
    input wire func_pu_i,
    input wire gpio_data_i,
    input wire gpio_dir_i,
    input wire gpio_pu_i,
    output reg pad_out_o,
    output reg pad_oe_o,
    output reg pad_pu_o
);

    reg next_out;
    reg next_oe;
    reg next_pu;

    // ====
    // Output select
    always @* begin
        if (own_i) begin
            next_out = func_out_i;
            next_oe = func_oe_i;
            next_pu = func_pu_i;
        end else begin
            next_out = gpio_data_i;
            next_oe = gpio_dir_i;
            next_pu = gpio_pu_i & ~gpio_dir_i;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pad_out_o <= `PPS_PAD_RESET_OUT;
            pad_oe_o <= `PPS_PAD_RESET_OE;
            pad_pu_o <= `PPS_PAD_RESET_PU;
        end else begin
            pad_out_o <= next_out;
            pad_oe_o <= next_oe;
            pad_pu_o <= next_pu;
        end
    end

endmodule

// File: testbench/pps_mux_checker.sv
// Concurrent checks on the pin share multiplexer ports.
// Assumes binding into pps_mux; outputs lag inputs by one clock.
module pps_mux_checker (
    input clk_i,
    input reset_i,
    input [7:0] p1_dir_i,
    input [7:0] p1_pad_oe_o,
    input [7:0] p1_pad_pu_o,
    input [7:0] p1_shared_o,
    input [7:0] p2_data_i,
    input [7:0] p2_dir_i,
    input [7:0] p2_pullup_i,
    input [7:0] p2_pad_in_i,
    input [7:0] p2_pad_out_o,
    input [7:0] p2_pad_oe_o,
    input [7:0] p2_pad_pu_o,
    input ext_int_group4_enable_i,
    input [7:0] int_group4_source_select_i,
    input [3:0] adc_pin_channel_connect_i,
    input converter_power_on_i,
    input [2:0] converter_channel_select_i,
    input [3:0] analog_input_connect_o,
    input timer0_run_i,
    input timer0_counter_mode_i,
    input pwm_out11_enable_i,
    input pwm_out11_i,
    input pwm_ch1_enable_i,
    input pwm_ch0_enable_i,
    input pwm_ch0_i,
    input uart_rx_enable_i,
    input uart_txd_i,
    input uart_rxd_o,
    input uart_tx_owned_o,
    input spi_mosi_in_o,
    input buzzer_enable_i,
    input buzzer_output_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ====
    // Settling counter after reset
    logic [1:0] live_cnt;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            live_cnt <= 2'h0;
        end else if (live_cnt != 2'h3) begin
            live_cnt <= live_cnt + 2'h1;
        end
    end
    wire live = (live_cnt == 2'h3);
    // ====
    // Properties
    property p_irq_own;
        live && $past(ext_int_group4_enable_i) && $past(int_group4_source_select_i[7]) && !$past(p1_dir_i[0])
            |-> p1_shared_o[0] && !p1_pad_oe_o[0];
    endproperty
    a_irq_own: assert property (p_irq_own) else $error("irq pin not owned");
    property p_adc;
        live |-> analog_input_connect_o[0] == ($past(adc_pin_channel_connect_i[0]) && $past(converter_power_on_i)
            && $past(converter_channel_select_i) == 3'h4 && !($past(ext_int_group4_enable_i)
            && $past(int_group4_source_select_i[3]) && !$past(p1_dir_i[2])));
    endproperty
    a_adc: assert property (p_adc) else $error("analog switch wrong");
    property p_timer;
        live && $past(timer0_run_i) && $past(timer0_counter_mode_i) |-> p1_pad_pu_o[6] && !p1_pad_oe_o[6] && p1_shared_o[6];
    endproperty
    a_timer: assert property (p_timer) else $error("timer pin wrong");
    property p_pwm0;
        live && $past(pwm_ch0_enable_i) |-> p2_pad_oe_o[4] && p2_pad_out_o[4] == $past(pwm_ch0_i);
    endproperty
    a_pwm0: assert property (p_pwm0) else $error("pwm0 pin wrong");
    property p_pwm11;
        live && $past(pwm_out11_enable_i) |-> p2_pad_oe_o[7] && p2_pad_out_o[7] == $past(pwm_out11_i);
    endproperty
    a_pwm11: assert property (p_pwm11) else $error("pwm11 pin wrong");
    property p_rx;
        live && $past(uart_rx_enable_i) |-> p2_pad_pu_o[2] && !p2_pad_oe_o[2] && spi_mosi_in_o
            && uart_rxd_o == $past(p2_pad_in_i[2]);
    endproperty
    a_rx: assert property (p_rx) else $error("rx pin wrong");
    property p_tx;
        live && uart_tx_owned_o |-> p2_pad_oe_o[1] && p2_pad_out_o[1] == $past(uart_txd_i);
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin wrong");
    property p_buz;
        live && $past(buzzer_enable_i) |-> p2_pad_oe_o[0] && p2_pad_out_o[0] == $past(buzzer_output_i);
    endproperty
    a_buz: assert property (p_buz) else $error("buzzer pin wrong");
    property p_gpio;
        live && !$past(pwm_ch1_enable_i) |-> p2_pad_oe_o[5] == $past(p2_dir_i[5])
            && p2_pad_out_o[5] == $past(p2_data_i[5]) && p2_pad_pu_o[5] == ($past(p2_pullup_i[5]) && !$past(p2_dir_i[5]));
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio pin wrong");
    c_tx: cover property (uart_tx_owned_o ##1 p2_pad_oe_o[1]);
    c_irq: cover property (ext_int_group4_enable_i && adc_pin_channel_connect_i[0]);
    c_buz: cover property (buzzer_enable_i && p2_pad_oe_o[0]);
endmodule

bind pps_mux pps_mux_checker u_chk (.*);

// File: testbench/pps_board.sv
// Board side of one 8-pin port: resolves each pad level.
// Assumes the bench says which pins it drives externally.
module pps_board (
    input clk_i,
    input [7:0] pad_out_i,
    input [7:0] pad_oe_i,
    input [7:0] pad_pu_i,
    input [7:0] drive_i,
    input [7:0] drive_oe_i,
    output logic [7:0] pad_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven pins without pull-up wander every cycle
    logic [7:0] float_lvl = 8'h55;
    always @(posedge clk_i) float_lvl <= ~float_lvl;
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & drive_oe_i & drive_i)
        | (~pad_oe_i & ~drive_oe_i & (pad_pu_i | float_lvl));
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the pin share multiplexer.
// Assumes pps_mux, pps_board and the bound checker are compiled.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, reset_i, ext_int_group4_enable_i, converter_power_on_i, timer0_run_i, timer0_counter_mode_i;
    logic reset_pin_option_i, pwm_out11_enable_i, pwm_out01_enable_i, pwm_ch1_enable_i, pwm_ch0_enable_i;
    logic pwm_ch2_enable_i, pwm_out11_i, pwm_out01_i, pwm_ch1_i, pwm_ch0_i, pwm_ch2_i, uart_rx_enable_i;
    logic uart_tx_buffer_write_i, uart_tx_release_i, uart_txd_i, spi_enable_i, spi_master_i, spi_clock_phase_i;
    logic slave_select_disable_i, spi_miso_out_i, spi_sck_out_i, buzzer_enable_i, buzzer_output_i;
    logic [7:0] p1_data_i, p1_dir_i, p1_pullup_i, p2_data_i, p2_dir_i, p2_pullup_i, int_group4_source_select_i;
    logic [7:0] ext1, ext1_oe, ext2, ext2_oe;
    logic [3:0] adc_pin_channel_connect_i;
    logic [2:0] converter_channel_select_i;
    wire [7:0] p1_pad_in_i, p1_pad_out_o, p1_pad_oe_o, p1_pad_pu_o, p1_pin_read_o, p1_shared_o;
    wire [7:0] p2_pad_in_i, p2_pad_out_o, p2_pad_oe_o, p2_pad_pu_o, p2_pin_read_o, p2_shared_o, group4_irq_o;
    wire [3:0] analog_input_connect_o;
    wire timer0_ext_input_o, reset_pin_selected_o, reset_pin_level_o, uart_rxd_o, uart_tx_owned_o;
    wire spi_mosi_in_o, spi_miso_in_o, spi_sck_in_o;
    int err_count = 0, check_count = 0;
    pps_mux u_dut (.*);
    pps_board u_brd1 (.clk_i(clk_i), .pad_out_i(p1_pad_out_o), .pad_oe_i(p1_pad_oe_o), .pad_pu_i(p1_pad_pu_o),
        .drive_i(ext1), .drive_oe_i(ext1_oe), .pad_in_o(p1_pad_in_i));
    pps_board u_brd2 (.clk_i(clk_i), .pad_out_i(p2_pad_out_o), .pad_oe_i(p2_pad_oe_o), .pad_pu_i(p2_pad_pu_o),
        .drive_i(ext2), .drive_oe_i(ext2_oe), .pad_in_o(p2_pad_in_i));
    // ====
    // Tasks
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task do_reset(input logic opt);
        @(posedge clk_i);
        reset_i <= 1'b1;
        reset_pin_option_i <= opt;
        p1_dir_i <= 8'h80;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        settle;
    endtask
    task wrap_up;
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ====
    // Clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        err_count++;
        wrap_up;
    end
    // ====
    // Tests
    initial begin
        {ext_int_group4_enable_i, converter_power_on_i, timer0_run_i, timer0_counter_mode_i, pwm_out11_enable_i,
            pwm_out01_enable_i, pwm_ch1_enable_i, pwm_ch0_enable_i, pwm_ch2_enable_i, pwm_out11_i, pwm_out01_i,
            pwm_ch1_i, pwm_ch0_i, pwm_ch2_i, uart_rx_enable_i, uart_tx_buffer_write_i, uart_tx_release_i,
            uart_txd_i, spi_enable_i, spi_master_i, spi_clock_phase_i, slave_select_disable_i, spi_miso_out_i,
            spi_sck_out_i, buzzer_enable_i, buzzer_output_i, p1_data_i, p1_dir_i, p1_pullup_i, p2_data_i,
            p2_dir_i, p2_pullup_i, int_group4_source_select_i, ext1, ext1_oe, ext2, ext2_oe,
            adc_pin_channel_connect_i, converter_channel_select_i} = '0;
        reset_i = 1'b1;
        do_reset(1'b1);
        chk("rst_sel", 8'h01, {7'h00, reset_pin_selected_o});
        chk("p1_oe", 8'h00, p1_pad_oe_o);
        @(posedge clk_i);
        p2_dir_i <= 8'h0f;
        p2_data_i <= 8'ha5;
        p2_pullup_i <= 8'hff;
        settle;
        chk("p2_oe", 8'h0f, p2_pad_oe_o);
        chk("p2_out", 8'ha5, p2_pad_out_o);
        chk("p2_pu", 8'hf0, p2_pad_pu_o);
        chk("p2_rd", 8'hf5, p2_pin_read_o);
        chk("p2_sh", 8'h00, p2_shared_o);
        @(posedge clk_i);
        {pwm_out11_enable_i, pwm_out01_enable_i, pwm_ch1_enable_i, pwm_ch0_enable_i, pwm_ch2_enable_i} <= 5'h1f;
        {pwm_out11_i, pwm_out01_i, pwm_ch1_i, pwm_ch0_i, pwm_ch2_i} <= 5'h15;
        ext_int_group4_enable_i <= 1'b1;
        int_group4_source_select_i <= 8'h60;
        p2_data_i <= 8'h5a;
        settle;
        chk("p2_oe", 8'hff, p2_pad_oe_o);
        chk("p2_out", 8'haa, p2_pad_out_o);
        chk("irq", 8'hff, group4_irq_o);
        chk("p2_sh", 8'hf8, p2_shared_o);
        @(posedge clk_i);
        {pwm_out11_enable_i, pwm_out01_enable_i} <= 2'h0;
        ext2_oe <= 8'hc0;
        settle;
        chk("p2_oe", 8'h3f, p2_pad_oe_o);
        chk("irq", 8'h9f, group4_irq_o);
        @(posedge clk_i);
        {pwm_ch1_enable_i, pwm_ch0_enable_i, pwm_ch2_enable_i, ext_int_group4_enable_i} <= 4'h0;
        settle;
        chk("p2_oe", 8'h0f, p2_pad_oe_o);
        chk("p2_out", 8'h5a, p2_pad_out_o);
        chk("p2_sh", 8'h00, p2_shared_o);
        @(posedge clk_i);
        adc_pin_channel_connect_i <= 4'hf;
        converter_power_on_i <= 1'b1;
        p1_dir_i <= 8'h00;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            converter_channel_select_i <= 3'(4 + k);
            settle;
            chk("adc", 8'(1 << k), {4'h0, analog_input_connect_o});
        end
        @(posedge clk_i);
        converter_channel_select_i <= 3'h4;
        ext_int_group4_enable_i <= 1'b1;
        int_group4_source_select_i <= 8'h08;
        ext1_oe <= 8'h04;
        settle;
        chk("adc", 8'h00, {4'h0, analog_input_connect_o});
        chk("irq", 8'hf7, group4_irq_o);
        chk("p1_sh", 8'h04, p1_shared_o & 8'h7f);
        @(posedge clk_i);
        p1_dir_i <= 8'h04;
        settle;
        chk("adc", 8'h01, {4'h0, analog_input_connect_o});
        chk("irq", 8'hff, group4_irq_o);
        @(posedge clk_i);
        adc_pin_channel_connect_i <= 4'h0;
        settle;
        chk("p1_sh", 8'h00, p1_shared_o & 8'h7f);
        chk("p1_oe", 8'h04, p1_pad_oe_o & 8'h7f);
        @(posedge clk_i);
        timer0_run_i <= 1'b1;
        timer0_counter_mode_i <= 1'b1;
        settle;
        chk("p1_pu", 8'h40, p1_pad_pu_o & 8'h40);
        chk("t0_in", 8'h01, {7'h00, timer0_ext_input_o});
        @(posedge clk_i);
        ext1_oe <= 8'h44;
        settle;
        chk("t0_in", 8'h00, {7'h00, timer0_ext_input_o});
        @(posedge clk_i);
        {spi_enable_i, spi_clock_phase_i, slave_select_disable_i, spi_miso_out_i} <= 4'hf;
        {p2_dir_i, p2_pullup_i, ext2, ext2_oe} <= {16'h0000, 8'h00, 8'h05};
        settle;
        chk("p2_pu", 8'h05, p2_pad_pu_o & 8'h07);
        chk("p2_oe", 8'h02, p2_pad_oe_o & 8'h07);
        chk("p2_out", 8'h02, p2_pad_out_o & 8'h02);
        chk("mosi", 8'h00, {7'h00, spi_mosi_in_o});
        chk("sck", 8'h00, {7'h00, spi_sck_in_o});
        @(posedge clk_i);
        uart_rx_enable_i <= 1'b1;
        settle;
        chk("rxd", 8'h00, {7'h00, uart_rxd_o});
        chk("mosi", 8'h01, {7'h00, spi_mosi_in_o});
        @(posedge clk_i);
        {buzzer_enable_i, buzzer_output_i, spi_master_i, spi_clock_phase_i} <= 4'he;
        ext2_oe <= 8'h04;
        settle;
        chk("p2_oe", 8'h01, p2_pad_oe_o & 8'h07);
        chk("p2_out", 8'h01, p2_pad_out_o & 8'h01);
        chk("p2_pu", 8'h06, p2_pad_pu_o & 8'h07);
        @(posedge clk_i);
        uart_tx_buffer_write_i <= 1'b1;
        @(posedge clk_i);
        uart_tx_buffer_write_i <= 1'b0;
        settle;
        chk("tx_own", 8'h01, {7'h00, uart_tx_owned_o});
        chk("p2_oe", 8'h03, p2_pad_oe_o & 8'h07);
        chk("p2_out", 8'h01, p2_pad_out_o & 8'h03);
        @(posedge clk_i);
        uart_tx_release_i <= 1'b1;
        @(posedge clk_i);
        uart_tx_release_i <= 1'b0;
        settle;
        chk("p2_oe", 8'h01, p2_pad_oe_o & 8'h07);
        do_reset(1'b0);
        chk("rst_sel", 8'h00, {7'h00, reset_pin_selected_o});
        chk("p1_oe", 8'h80, p1_pad_oe_o);
        wrap_up;
    end
endmodule
